// >>> core/capture_match_timer16.sv
`timescale 1ns/1ps
`include "timer16_defs.svh"
// Behaviour
// - clock source select, full only timer1
// - match inputs from previous timer or lse/lsi
// - lock bit blocks value update on write
// - freeze in debug unless debug run set
// - io swap exchanges capture and match pins
// - timer or edge counting on chosen input
// - writing reset bit clears both counts
// - prescale counts to limit then wraps
// - main count steps on prescale wrap
// - capture filter length and invert bits
// - capture edges load count into register
// - extended action: hold low, reset fall
// - capture action: hold, reset, start
// - match input action: hold, reset, start
// - output mask forces low by capture
// - value bit plus invert drives output
// - match clears, sets or toggles value
// - 1b reset and 1a above 1b: toggle
// - match stop clears run, reset resets
// - wrap and capture overrun flags, w1c
// - eight irq flags gated by enables
// - eight dma flags gated by enables
// - timer off clears flags, holds counter
// - reset beats hold
// - a match beats b match on a channel
// - irq only while a flag is set
module capture_match_timer16 #(
	parameter int TIMER_INDEX = 1  // index 1 takes all clock sources
)(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire timer16_pkg::avs_req_s avs_req,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  msi_tick,
	input  wire logic                  hsi_tick,
	input  wire logic                  tmr1_cap0,
	input  wire logic                  lse_clk,
	input  wire logic                  lsi_clk,
	input  wire logic [1:0]            prev_match,
	input  wire logic                  debug_halted,
	input  wire logic [3:0]            timer_channel_pins_in,
	output logic [3:0]                 timer_channel_pins_out,
	output logic [3:0]                 timer_channel_pins_oe_n,
	output logic [1:0]                 match_out,
	output logic                       irq,
	output logic                       dma_req
);
	// bus handshake
	logic        ack_r;       // second cycle of access
	logic        wr_en;       // write takes effect
	logic [15:0] wd;          // low write lanes
	logic [15:0] wm;          // lane mask
	// registers
	logic [15:0] ctl_r;       // control less run bit
	logic        st_r;        // run bit
	logic [15:0] tcnt_r;      // main count
	logic [15:0] pcnt_r;      // prescale count
	logic [15:0] pscl_r;      // prescale limit
	logic [15:0] cctl_r;      // filter and capture
	logic [15:0] cictl_r;     // input actions
	logic [15:0] mctl_r;      // match output control
	logic [1:0]  mv_r;        // match output values
	logic [1:0]  mv_nxt;
	logic [7:0]  moctl_r;     // match stop/reset
	logic [15:0] mat_r [4];   // shared match/capture
	logic [15:0] ofif_r;      // overflow and irq flags
	logic [15:0] ofif_nxt;    // flags as of the next edge
	logic [7:0]  ie_r;
	logic [7:0]  rf_r;
	logic [7:0]  re_r;
	logic [31:0] rdata_r;
	// conditioning
	logic [1:0]  craw;        // pins after swap/invert
	logic [1:0]  capf_r;      // filtered captures
	logic [6:0]  fcnt_r [2];  // filter stability count
	logic [6:0]  flim;
	logic [1:0]  mati;
	logic [3:0]  sig;         // {mati1, mati0, cap1, cap0}
	logic [3:0]  hist_r;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic        srcp_r;
	logic        src_tick;
	logic        tick;
	// control
	logic        en;
	logic [1:0]  clksel;
	logic [1:0]  sel;
	logic [1:0]  mode;
	logic        hold;
	logic        in_rst;
	logic        trig;
	logic        sw_rst;
	logic        cnt_rst;
	logic        cnt_wr;
	logic        freeze;
	logic        run;
	logic        step;
	logic        pwrap;
	logic        twrap;
	logic [3:0]  meq;
	logic [3:0]  eqp_r;
	logic [3:0]  mev;         // match events
	logic [3:0]  cev;         // capture events
	logic [7:0]  ev;
	logic        mstop;
	logic        mrst;
	logic [1:0]  mo;
	logic [1:0]  mato_r;
	logic [3:0]  pin_r;
	logic [3:0]  oen_r;
	logic        irq_r;
	logic        dma_r;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] m);
		return (old & ~m) | (nw & m);
	endfunction

	function automatic logic act(input logic v, input logic [1:0] code);
		unique case (code)
			2'h1: return 1'b0;
			2'h2: return 1'b1;
			2'h3: return ~v;
			2'h0: return v;
		endcase
	endfunction

	function automatic logic hit(input logic we, input logic [6:0] a, input logic [6:0] ofs);
		return we && (a == ofs);
	endfunction

	// one wait state; reads stand at the release edge
	assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_r;
	assign wr_en = avs_req.write & ack_r;
	assign wd = avs_req.writedata[15:0];
	assign wm = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
	assign avs_readdata = rdata_r;

	// ack toggles so back to back requests stay paced
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_req.read | avs_req.write) & ~ack_r;
		end
	end

	// field decode
	assign en = ctl_r[`T16_CTL_EN];
	assign clksel = (TIMER_INDEX == 1) ? ctl_r[`T16_CTL_CLKSEL +: 2] : 2'h0;
	assign sel = ctl_r[`T16_CTL_SEL +: 2];
	assign mode = ctl_r[`T16_CTL_MODE +: 2];
	assign sw_rst = hit(wr_en, avs_req.address, `T16_OFS_CTL) & avs_req.byteenable[0]
		& wd[`T16_CTL_RST];
	assign cnt_wr = hit(wr_en, avs_req.address, `T16_OFS_TCNT)
		| hit(wr_en, avs_req.address, `T16_OFS_PCNT);

	// pin routing; invert applied ahead of the filter
	assign craw = (ctl_r[`T16_CTL_IOSW] ? timer_channel_pins_in[3:2] : timer_channel_pins_in[1:0])
		^ cctl_r[`T16_CCTL_INV +: 2];
	assign mati = ctl_r[`T16_CTL_MATISW] ? {lse_clk, lsi_clk} : prev_match;

	// filter length from setting
	always_comb begin
		unique case (cctl_r[`T16_CCTL_FLT +: 2])
			2'h0: flim = `T16_FLT_LEN0;
			2'h1: flim = `T16_FLT_LEN1;
			2'h2: flim = `T16_FLT_LEN2;
			2'h3: flim = `T16_FLT_LEN3;
		endcase
	end

	// filter: level must hold flim clocks to pass
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			capf_r <= 2'h0;
			fcnt_r[0] <= 7'h00;
			fcnt_r[1] <= 7'h00;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (craw[k] == capf_r[k]) begin
					fcnt_r[k] <= 7'h00;
				end else if (7'(fcnt_r[k] + 7'h01) >= flim) begin
					capf_r[k] <= craw[k];
					fcnt_r[k] <= 7'h00;
				end else begin
					fcnt_r[k] <= 7'(fcnt_r[k] + 7'h01);
				end
			end
		end
	end

	// edge history of all event inputs
	assign sig = {mati, capf_r};
	assign rise = sig & ~hist_r;
	assign fall = ~sig & hist_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hist_r <= 4'h0;
			srcp_r <= 1'b0;
			eqp_r <= 4'h0;
		end else begin
			hist_r <= sig;
			srcp_r <= tmr1_cap0;
			eqp_r <= meq;
		end
	end

	// count tick; sampled edges limit input to half the clock
	always_comb begin
		unique case (clksel)
			2'h0: src_tick = 1'b1;
			2'h1: src_tick = msi_tick;
			2'h2: src_tick = hsi_tick;
			2'h3: src_tick = tmr1_cap0 & ~srcp_r;
		endcase
		if (mode == 2'h0) begin
			tick = src_tick;
		end else begin
			tick = (mode[0] & rise[sel]) | (mode[1] & fall[sel]);
		end
	end

	// hold, reset and start from capture and match inputs
	always_comb begin
		hold = 1'b0;
		in_rst = 1'b0;
		trig = 1'b0;
		for (int k = 0; k < 4; k++) begin
			hold |= (cictl_r[2*k +: 2] == 2'h1) & sig[k];
			in_rst |= (cictl_r[2*k +: 2] == 2'h2) & rise[k];
			trig |= (cictl_r[2*k +: 2] == 2'h3) & rise[k];
		end
		for (int k = 0; k < 2; k++) begin
			hold |= (cictl_r[`T16_CICTL_EXT + 2*k +: 2] == 2'h1) & ~sig[k];
			in_rst |= (cictl_r[`T16_CICTL_EXT + 2*k +: 2] == 2'h2) & fall[k];
		end
		hold &= en;
		in_rst &= en;
		trig &= en;
	end

	// compare and capture events, all gated by enable
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			meq[i] = tcnt_r == mat_r[i];
		end
		mev = en ? (meq & ~eqp_r) : 4'h0;  // entry into equality only
		cev = en ? (cctl_r[3:0] & {fall[1], rise[1], fall[0], rise[0]}) : 4'h0;
		ev = {mev, cev};
		mrst = |(mev & {moctl_r[6], moctl_r[4], moctl_r[2], moctl_r[0]});
		mstop = |(mev & {moctl_r[7], moctl_r[5], moctl_r[3], moctl_r[1]});
	end

	// counter control; debug freeze acts as a hold
	assign freeze = debug_halted & ~ctl_r[`T16_CTL_DE];
	assign cnt_rst = sw_rst | in_rst | mrst;
	assign run = en & st_r & ~hold & ~freeze;
	assign step = run & tick;
	assign pwrap = step & (pcnt_r == pscl_r);
	assign twrap = pwrap & (tcnt_r == 16'hffff);

	// counts; reset first, then software write, then count
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tcnt_r <= `T16_RST_VAL;
			pcnt_r <= `T16_RST_VAL;
		end else if (cnt_rst) begin
			tcnt_r <= `T16_RST_VAL;
			pcnt_r <= `T16_RST_VAL;
		end else begin
			if (hit(wr_en, avs_req.address, `T16_OFS_TCNT)) begin
				tcnt_r <= merge(tcnt_r, wd, wm);
			end else if (pwrap) begin
				tcnt_r <= tcnt_r + 16'h0001;
			end
			if (hit(wr_en, avs_req.address, `T16_OFS_PCNT)) begin
				pcnt_r <= merge(pcnt_r, wd, wm);
			end else if (step) begin
				pcnt_r <= pwrap ? 16'h0000 : pcnt_r + 16'h0001;
			end
		end
	end

	// run bit; hardware start wins over stop and software
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r <= 1'b0;
		end else if (trig) begin
			st_r <= 1'b1;
		end else if (mstop) begin
			st_r <= 1'b0;
		end else if (hit(wr_en, avs_req.address, `T16_OFS_CTL) && avs_req.byteenable[0]) begin
			st_r <= wd[`T16_CTL_ST];
		end
	end

	// plain configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctl_r <= `T16_RST_VAL;
			pscl_r <= `T16_RST_VAL;
			cctl_r <= `T16_RST_VAL;
			cictl_r <= `T16_RST_VAL;
			mctl_r <= `T16_RST_VAL;
			moctl_r <= 8'h00;
			ie_r <= 8'h00;
			re_r <= 8'h00;
		end else if (wr_en) begin
			unique case (avs_req.address)
				`T16_OFS_CTL: ctl_r <= merge(ctl_r, wd, wm) & `T16_CTL_KEEP;
				`T16_OFS_PSCL: pscl_r <= merge(pscl_r, wd, wm);
				`T16_OFS_CCTL: cctl_r <= merge(cctl_r, wd, wm) & 16'h0f0f;
				`T16_OFS_CICTL: cictl_r <= merge(cictl_r, wd, wm) & 16'h0fff;
				`T16_OFS_MCTL: mctl_r <= merge(mctl_r, wd, wm) & 16'hf3ff;
				`T16_OFS_MOCTL: moctl_r <= 8'(merge({8'h00, moctl_r}, wd, wm));
				`T16_OFS_IE: ie_r <= 8'(merge({8'h00, ie_r}, wd, wm));
				`T16_OFS_RE: re_r <= 8'(merge({8'h00, re_r}, wd, wm));
				default: ;
			endcase
		end
	end

	// shared registers; a capture beats a software write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				mat_r[i] <= `T16_RST_VAL;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (cev[i]) begin
					mat_r[i] <= tcnt_r;
				end else if (hit(wr_en, avs_req.address, 7'(`T16_OFS_MAT0A + 4 * i))) begin
					mat_r[i] <= merge(mat_r[i], wd, wm);
				end
			end
		end
	end

	// match values: write first, then match action on top
	always_comb begin
		logic [1:0] code;
		code = 2'h0;
		mv_nxt = mv_r;
		if (hit(wr_en, avs_req.address, `T16_OFS_MCTL) && avs_req.byteenable[1]
			&& !ctl_r[`T16_CTL_MATCO]) begin
			mv_nxt = wd[`T16_MCTL_VAL +: 2];
		end
		for (int c = 0; c < 2; c++) begin
			if (mev[2*c]) begin
				code = mctl_r[4*c +: 2];
			end else if (mev[2*c+1]) begin
				code = mctl_r[4*c+2 +: 2];
			end else begin
				code = 2'h0;
			end
			// clear/set become toggle on the reset-by-1b case
			if (c == 1 && moctl_r[`T16_COMPARE1B_RESET_ENABLE] && mat_r[2] > mat_r[3]
				&& (code == 2'h1 || code == 2'h2)) begin
				code = 2'h3;
			end
			mv_nxt[c] = act(mv_nxt[c], code);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mv_r <= 2'h0;
		end else begin
			mv_r <= mv_nxt;
		end
	end

	// mask works only while enabled and running
	always_comb begin
		logic [1:0] mk;
		mk = 2'h0;
		for (int c = 0; c < 2; c++) begin
			mk = mctl_r[`T16_MCTL_MASK + 2*c +: 2];
			mo[c] = (mv_r[c] & ~(en & st_r & ((mk == 2'h2 & capf_r[0]) | (mk == 2'h3 & capf_r[1]))))
				^ mctl_r[`T16_MCTL_INV + c];
		end
	end

	// registered pins; undriven pins leave enable high
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mato_r <= 2'h0;
			pin_r <= 4'h0;
			oen_r <= 4'hf;
		end else begin
			mato_r <= mo;
			pin_r <= ctl_r[`T16_CTL_IOSW] ? {2'h0, mo} : {mo, 2'h0};
			oen_r <= ctl_r[`T16_CTL_IOSW] ? `T16_OEN_IOSW1 : `T16_OEN_IOSW0;
		end
	end

	assign match_out = mato_r;
	assign timer_channel_pins_out = pin_r;
	assign timer_channel_pins_oe_n = oen_r;

	// next flags, shared with irq so the line never outlives a cleared flag
	assign ofif_nxt = (ofif_r & ~(hit(wr_en, avs_req.address, `T16_OFS_OFIF) ? wd & wm : 16'h0000))
		| {twrap, 3'h0, cev & ofif_r[3:0], ev & ie_r};

	// flags: set wins over write-one clear; off clears all
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !en) begin
			ofif_r <= `T16_RST_VAL;
			rf_r <= 8'h00;
		end else begin
			ofif_r <= ofif_nxt;
			rf_r <= (rf_r & ~(hit(wr_en, avs_req.address, `T16_OFS_RF) ? wd[7:0] & wm[7:0] : 8'h00))
				| (ev & re_r);
		end
	end

	// irq loads with the flags themselves; dma request lags them a cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
			dma_r <= 1'b0;
		end else begin
			irq_r <= en & (|ofif_nxt);
			dma_r <= |rf_r;
		end
	end

	assign irq = irq_r;
	assign dma_req = dma_r;

	// read mux, loaded in the wait cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_r <= 32'h0;
		end else if (avs_req.read && !ack_r) begin
			rdata_r[31:16] <= 16'h0;
			unique case (avs_req.address)
				`T16_OFS_CTL: rdata_r[15:0] <= ctl_r | {15'h0, st_r};
				`T16_OFS_TCNT: rdata_r[15:0] <= tcnt_r;
				`T16_OFS_PSCL: rdata_r[15:0] <= pscl_r;
				`T16_OFS_PCNT: rdata_r[15:0] <= pcnt_r;
				`T16_OFS_CCTL: rdata_r[15:0] <= cctl_r;
				`T16_OFS_CICTL: rdata_r[15:0] <= cictl_r;
				`T16_OFS_MCTL: rdata_r[15:0] <= mctl_r | {4'h0, mv_r, 10'h0};
				`T16_OFS_MOCTL: rdata_r[15:0] <= {8'h00, moctl_r};
				`T16_OFS_MAT0A: rdata_r[15:0] <= mat_r[0];
				`T16_OFS_MAT0B: rdata_r[15:0] <= mat_r[1];
				`T16_OFS_MAT1A: rdata_r[15:0] <= mat_r[2];
				`T16_OFS_MAT1B: rdata_r[15:0] <= mat_r[3];
				`T16_OFS_OFIF: rdata_r[15:0] <= ofif_r;
				`T16_OFS_IE: rdata_r[15:0] <= {8'h00, ie_r};
				`T16_OFS_RF: rdata_r[15:0] <= {8'h00, rf_r};
				`T16_OFS_RE: rdata_r[15:0] <= {8'h00, re_r};
				default: rdata_r[15:0] <= 16'h0;  // unmapped reads zero
			endcase
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_cnt_rst;
		sw_rst |=> tcnt_r == 16'h0 && pcnt_r == 16'h0;
	endproperty
	a_cnt_rst: assert property (p_cnt_rst) else $error("counter reset lost");

	property p_wrap;
		pwrap && !cnt_rst && !cnt_wr |=> pcnt_r == 16'h0 && tcnt_r == $past(tcnt_r) + 16'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("prescale wrap wrong");

	property p_hold;
		hold && !cnt_rst && !cnt_wr |=> $stable(tcnt_r) && $stable(pcnt_r);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved in hold");

	property p_rst_prio;
		hold && in_rst |=> pcnt_r == 16'h0 && tcnt_r == 16'h0;
	endproperty
	a_rst_prio: assert property (p_rst_prio) else $error("hold beat reset");

	property p_freeze;
		freeze && !cnt_rst && !cnt_wr |=> $stable(pcnt_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved in debug");

	property p_off;
		!en |=> ofif_r == 16'h0 && rf_r == 8'h0;
	endproperty
	a_off: assert property (p_off) else $error("flags kept while off");

	property p_irq;
		1'b1 |-> irq == (ofif_r != 16'h0);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not tied to flags");

	property p_dma;
		(ev & re_r) != 8'h0 |=> rf_r != 8'h0 ##1 dma_req;
	endproperty
	a_dma: assert property (p_dma) else $error("dma request missing");

	property p_stop;
		mev[3] && moctl_r[7] && !trig |=> !st_r;
	endproperty
	a_stop: assert property (p_stop) else $error("stop on match failed");

	property p_twrap;
		twrap |=> ofif_r[`T16_COUNTER_WRAP_FLAG];
	endproperty
	a_twrap: assert property (p_twrap) else $error("wrap flag missing");
endmodule

// >>> core/timer16_defs.svh
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH
`define T16_OFS_CTL 7'h00
`define T16_OFS_TCNT 7'h04
`define T16_OFS_PSCL 7'h08
`define T16_OFS_PCNT 7'h0c
`define T16_OFS_CCTL 7'h10
`define T16_OFS_CICTL 7'h14
`define T16_OFS_MCTL 7'h18
`define T16_OFS_MOCTL 7'h1c
`define T16_OFS_MAT0A 7'h30
`define T16_OFS_MAT0B 7'h34
`define T16_OFS_MAT1A 7'h38
`define T16_OFS_MAT1B 7'h3c
`define T16_OFS_OFIF 7'h40
`define T16_OFS_IE 7'h44
`define T16_OFS_RF 7'h48
`define T16_OFS_RE 7'h4c
`define T16_CTL_EN 15
`define T16_CTL_CLKSEL 10
`define T16_CTL_MATISW 9
`define T16_CTL_MATCO 8
`define T16_CTL_DE 7
`define T16_CTL_IOSW 6
`define T16_CTL_SEL 4
`define T16_CTL_MODE 2
`define T16_CTL_RST 1
`define T16_CTL_ST 0
`define T16_CTL_KEEP 16'h8ffc
`define T16_CCTL_FLT 10
`define T16_CCTL_INV 8
`define T16_CICTL_EXT 8
`define T16_MCTL_MASK 12
`define T16_MCTL_VAL 10
`define T16_MCTL_INV 8
`define T16_COMPARE1B_RESET_ENABLE 6
`define T16_COUNTER_WRAP_FLAG 15
`define T16_OF_CAP 8
`define T16_RST_VAL 16'h0000
`define T16_FLT_LEN0 7'h01
`define T16_FLT_LEN1 7'h04
`define T16_FLT_LEN2 7'h10
`define T16_FLT_LEN3 7'h40
`define T16_OEN_IOSW0 4'h3
`define T16_OEN_IOSW1 4'hc
`endif

// >>> core/timer16_pkg.sv
package timer16_pkg;
	// one avalon request as driven by the master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [6:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avs_req_s;
endpackage

// >>> verif/pin_partner.sv
`timescale 1ns/1ps
// far side: capture sources and the previous timer's match pair
module pin_partner (
	input  wire logic       ref_clk,
	input  wire logic [1:0] cap_lvl,   // capture levels asked by bench
	input  wire logic [1:0] pm_lvl,    // neighbour match levels
	input  wire logic [3:0] pins_out,  // design pin drive
	input  wire logic [3:0] pins_oe_n, // low where design drives
	output logic [3:0]      pins_in,   // resolved pin levels
	output logic [1:0]      prev_match // neighbour match outputs
);
	logic [3:0] ext_drv; // partner drive on the free pair
	// captures sit on whichever pair the design leaves undriven
	always_comb begin
		ext_drv = pins_oe_n[0] ? {2'b00, cap_lvl} : {cap_lvl, 2'b00};
		for (int i = 0; i < 4; i++) begin
			pins_in[i] = pins_oe_n[i] ? ext_drv[i] : pins_out[i];
		end
	end
	// registered, as a real neighbour timer's outputs are
	always @(posedge ref_clk) begin
		prev_match <= pm_lvl;
	end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic                  ref_clk = 1'b0;
	logic                  rst_n = 1'b0;
	timer16_pkg::avs_req_s avs_req = '0;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	logic                  debug_halted = 1'b0;
	logic [1:0]            cap_lvl = 2'b00;   // partner capture levels
	logic [1:0]            pm_lvl = 2'b00;    // neighbour match levels
	logic                  lsi_lvl = 1'b0;    // low-speed internal level
	logic [3:0]            pins_in;
	logic [3:0]            pins_out;
	logic [3:0]            pins_oe_n;
	logic [1:0]            prev_match;
	logic [1:0]            match_out;
	logic                  irq;
	logic                  dma_req;
	logic [31:0]           rd_q;              // last read data
	int                    fail_count = 0;
	int                    compares = 0;
	int                    cyc = 0;
	// 40 MHz
	always #12.5 ref_clk = ~ref_clk;
	capture_match_timer16 i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .msi_tick(1'b0), .hsi_tick(1'b0), .tmr1_cap0(1'b0),
		.lse_clk(1'b0), .lsi_clk(lsi_lvl), .prev_match(prev_match), .debug_halted(debug_halted),
		.timer_channel_pins_in(pins_in), .timer_channel_pins_out(pins_out),
		.timer_channel_pins_oe_n(pins_oe_n), .match_out(match_out), .irq(irq), .dma_req(dma_req)
	);
	pin_partner i_partner (
		.ref_clk(ref_clk), .cap_lvl(cap_lvl), .pm_lvl(pm_lvl), .pins_out(pins_out),
		.pins_oe_n(pins_oe_n), .pins_in(pins_in), .prev_match(prev_match)
	);
	// hang guard, far above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one avalon access; the leading edge keeps a release and the next rise apart
	// all drivers change by nba, so values read after an edge are what that edge sampled
	task automatic bus(input logic rd, input logic [6:0] adr, input logic [15:0] d);
		@(posedge ref_clk);
		avs_req <= '{read: rd, write: ~rd, address: adr, byteenable: 4'h3, writedata: {16'h0000, d}};
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd_q = avs_readdata;
		avs_req <= '0;
	endtask
	task automatic wr(input logic [6:0] adr, input logic [15:0] d);
		bus(1'b0, adr, d);
	endtask
	task automatic rchk(input string what, input logic [6:0] adr, input logic [15:0] exp);
		bus(1'b1, adr, 16'h0000);
		chk(what, {16'h0000, exp}, rd_q);
	endtask
	// capture pulse, then a quiet gap long enough for filter and edge detect
	task automatic pulse(input int ch, input int hi);
		@(posedge ref_clk);
		cap_lvl[ch] <= 1'b1;
		repeat (hi) @(posedge ref_clk);
		cap_lvl[ch] <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// reset values, plain rw, unmapped hole
	task automatic t_regs();
		logic [6:0] map [17];
		map = '{7'h00, 7'h04, 7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h1c, 7'h30,
			7'h34, 7'h38, 7'h3c, 7'h40, 7'h44, 7'h48, 7'h4c, 7'h20};
		foreach (map[i]) rchk("reset value", map[i], 16'h0000);
		wr(7'h08, 16'h00a5);
		rchk("prescale_limit", 7'h08, 16'h00a5);
		wr(7'h20, 16'hffff);
		rchk("unmapped", 7'h20, 16'h0000);
		$display("t_regs done");
	endtask
	// edge counting through the prescaler, reset before each mode
	task automatic t_edge_count();
		wr(7'h08, 16'h0001);
		for (int m = 1; m < 4; m++) begin
			wr(7'h00, 16'h8003 | 16'(m << 2));
			repeat (4) pulse(0, 4);
			rchk("main_count", 7'h04, (m == 3) ? 16'h0004 : 16'h0002);
			rchk("prescale_count", 7'h0c, 16'h0000);
		end
		rchk("timer_control", 7'h00, 16'h800d);
		$display("t_edge_count done");
	endtask
	// wrap of the main count, irq follows flag, w1c
	task automatic t_overflow();
		wr(7'h00, 16'h8000);
		wr(7'h08, 16'h0000);
		wr(7'h04, 16'hffff);
		wr(7'h0c, 16'h0000);
		wr(7'h00, 16'h8001);
		wr(7'h00, 16'h8000);
		rchk("wrap flag", 7'h40, 16'h8000);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(7'h40, 16'h8000);
		rchk("wrap cleared", 7'h40, 16'h0000);
		wait_cyc(3);
		chk("irq clear", 32'h0, {31'h0, irq});
		$display("t_overflow done");
	endtask
	// debug halt freezes counting when debug run is off
	task automatic t_debug();
		@(posedge ref_clk);
		debug_halted <= 1'b1;
		wr(7'h04, 16'h0000);
		wr(7'h00, 16'h8001);
		wait_cyc(20);
		wr(7'h00, 16'h8000);
		rchk("frozen count", 7'h04, 16'h0000);
		wr(7'h00, 16'h8081);
		wait_cyc(20);
		wr(7'h00, 16'h8080);
		// start write edge to stop write edge: 23 counting edges
		rchk("debug run counts", 7'h04, 16'h0017);
		debug_halted <= 1'b0;
		$display("t_debug done");
	endtask
	// captures, flags, dma request, overrun, filter, disable clears flags
	task automatic t_capture();
		wr(7'h44, 16'h0001);
		wr(7'h4c, 16'h0002);
		wr(7'h10, 16'h0003);
		wr(7'h04, 16'h1234);
		wr(7'h00, 16'h8015); // counts idle cap1 edges, so count holds still
		pulse(0, 4);
		rchk("capture rise", 7'h30, 16'h1234);
		rchk("capture fall", 7'h34, 16'h1234);
		rchk("irq flags", 7'h40, 16'h0001);
		rchk("dma flags", 7'h48, 16'h0002);
		chk("dma_req", 32'h1, {31'h0, dma_req});
		pulse(0, 4);
		rchk("overrun", 7'h40, 16'h0101);
		wr(7'h10, 16'h0403);
		wr(7'h04, 16'h0055);
		pulse(0, 2);
		rchk("short pulse", 7'h30, 16'h1234);
		pulse(0, 12);
		rchk("long pulse", 7'h30, 16'h0055);
		wr(7'h00, 16'h0000);
		rchk("flags off", 7'h40, 16'h0000);
		rchk("dma off", 7'h48, 16'h0000);
		$display("t_capture done");
	endtask
	// match set with stop, invert, lock, pin swap
	task automatic t_match();
		wr(7'h44, 16'h0000);
		wr(7'h4c, 16'h0000);
		wr(7'h10, 16'h0000);
		wr(7'h30, 16'h0003);
		wr(7'h1c, 16'h0002);
		wr(7'h18, 16'h0002);
		wr(7'h04, 16'h0000);
		wr(7'h0c, 16'h0000);
		wr(7'h00, 16'h8001);
		wait_cyc(20);
		rchk("run stopped", 7'h00, 16'h8000);
		rchk("match value", 7'h18, 16'h0402);
		chk("match_out", 32'h1, {30'h0, match_out});
		chk("pins_out", 32'h4, {28'h0, pins_out});
		chk("oe_n", 32'h3, {28'h0, pins_oe_n});
		wr(7'h18, 16'h0100);
		wait_cyc(3);
		chk("inverted out", 32'h1, {30'h0, match_out});
		wr(7'h00, 16'h8040);
		wait_cyc(3);
		chk("oe_n swapped", 32'hc, {28'h0, pins_oe_n});
		chk("pins swapped", 32'h1, {28'h0, pins_out});
		wr(7'h00, 16'h8140);
		wr(7'h18, 16'h0400);
		wait_cyc(3);
		chk("locked out", 32'h0, {30'h0, match_out});
		rchk("locked value", 7'h18, 16'h0000);
		$display("t_match done");
	endtask
	// swapped match input holds, capture rise resets, reset beats hold
	task automatic t_actions();
		wr(7'h1c, 16'h0000);
		wr(7'h14, 16'h0012);
		wr(7'h04, 16'h0040);
		lsi_lvl <= 1'b1;
		wr(7'h00, 16'h8201);
		wait_cyc(10);
		rchk("held count", 7'h04, 16'h0040);
		lsi_lvl <= 1'b0;
		wr(7'h00, 16'h8200);
		rchk("released count", 7'h04, 16'h0043);
		lsi_lvl <= 1'b1;
		pulse(0, 4);
		rchk("reset over hold", 7'h04, 16'h0000);
		$display("t_actions done");
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_edge_count();
		t_overflow();
		t_debug();
		t_capture();
		t_match();
		t_actions();
		complete_run();
	end
endmodule
